/* File: hdl/pir_defines.svh */
// Offsets, field positions and reset values of the peripheral interrupt
// registers. Assumes an APB slave with one 8-bit register per 32-bit word.
`ifndef PIR_DEFINES_SVH
`define PIR_DEFINES_SVH
`define PIR_OFF_CORE      12'h000
`define PIR_OFF_OPTION    12'h004
`define PIR_OFF_EN1       12'h008
`define PIR_OFF_EN2       12'h00C
`define PIR_OFF_EN3       12'h010
`define PIR_OFF_REQ1      12'h014
`define PIR_OFF_REQ2      12'h018
`define PIR_OFF_REQ3      12'h01C
`define PIR_OFF_IRQ_STAT  12'h020
`define PIR_OFF_IRQ_MASK  12'h024
`define PIR_MASK_CORE     8'hFF
`define PIR_MASK_CORE_WR  8'hFE
`define PIR_MASK_OPTION   8'hFF
`define PIR_MASK_EN1      8'hF3
`define PIR_MASK_EN1_NSER 8'hC3
`define PIR_MASK_EN2      8'h20
`define PIR_MASK_EN3      8'h70
`define PIR_MASK_REQ1_WR  8'hD3
`define PIR_MASK_REQ1_NSR 8'hC3
`define PIR_MASK_REQ2     8'h20
`define PIR_BIT_GIE       7
`define PIR_BIT_PERIPHERAL_GROUP_ENABLE      6
`define PIR_BIT_RX        5
`define PIR_BIT_TX        4
`define PIR_RESET_BYTE    8'h00
`define PIR_STAT_WIDTH    3
`define PIR_ST_REQ1       0
`define PIR_ST_REQ2       1
`define PIR_ST_REQ3       2
`endif

/* File: hdl/pir_flag_reg.sv */
// One 8-bit register of sticky flags: hardware sets, software writes.
// Assumes synchronous set pulses and a one-cycle write strobe.
`timescale 1ns/1ns
`include "pir_defines.svh"
module pir_flag_reg
(
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_nrst,
   // Software write
   input  wire logic       i_we,
   input  wire logic [7:0] i_wdata,
   input  wire logic [7:0] i_wmask,
   // Hardware set
   input  wire logic [7:0] i_set,
   // Stored value
   output logic      [7:0] o_q
);
   logic [7:0] flag_q;
   logic [7:0] flag_d;

   genvar b;
   generate
      for (b = 0; b < 8; b++)
      begin : g_bit
         always_comb
         begin
            flag_d[b] = flag_q[b];
            if (i_we && i_wmask[b])
               flag_d[b] = i_wdata[b];
            if (i_set[b] && i_wmask[b])
               flag_d[b] = 1'b1;
         end
      end
   endgenerate

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         flag_q <= `PIR_RESET_BYTE;
      else
         flag_q <= flag_d;
   end

   assign o_q = flag_q;
endmodule : pir_flag_reg

/* File: hdl/pir_pkg.sv */
// Types shared by the peripheral interrupt register block.
// Assumes the defines header is compiled alongside.
package pir_pkg;
   typedef struct packed {
      logic       psel;
      logic       penable;
      logic       pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } pir_apb_req_t;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } pir_apb_rsp_t;

   // Source events: one-cycle set pulses laid out as request registers, plus PWM flag levels
   typedef struct packed {
      logic [7:0] req1_set;
      logic [7:0] req2_set;
      logic [2:0] pwm_flags;
   } pir_src_t;

   typedef enum logic [1:0] {
      PIR_IDLE   = 2'b01,
      PIR_ACCESS = 2'b10
   } pir_bus_st_t;
endpackage : pir_pkg

/* File: hdl/pir_regs.sv */
// Peripheral interrupt enable and request registers on APB.
// Assumes sources give one-cycle set pulses and PWM flags are levels.
`timescale 1ns/1ns
`include "pir_defines.svh"
module pir_regs
#(
   parameter bit HAS_SERIAL = 1'b1
)
(
   // Clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_nrst,
   // APB slave
   input  wire pir_pkg::pir_apb_req_t i_apb,
   output pir_pkg::pir_apb_rsp_t      o_apb,
   // Peripheral sources
   input  wire pir_pkg::pir_src_t     i_src,
   input  wire logic                  i_serial_rx_pending,
   // Core-level flags from other logic
   input  wire logic [2:0]            i_core_flags,
   // Outputs
   output logic                       o_periph_irq,
   output logic                       o_cpu_irq,
   output logic                       o_irq
);
   import pir_pkg::*;

   typedef struct packed {
      pir_bus_st_t bus;
      logic [7:0]  core;
      logic [7:0]  option;
      logic [7:0]  en1;
      logic [7:0]  en2;
      logic [7:0]  en3;
      logic [2:0]  stat;
      logic [2:0]  mask;
      logic [2:0]  act_prev;
      logic [31:0] rdata;
      logic        periph;
      logic        cpu;
   } pir_state_t;

   pir_state_t s_q;
   pir_state_t s_d;

   logic [7:0] req1_q;
   logic [7:0] req2_q;
   logic [7:0] req1_rd;
   logic [7:0] req3_rd;
   logic [7:0] req1_set;
   logic [7:0] req1_wmask;
   logic [7:0] en1_mask;
   logic       wr_req1;
   logic       wr_req2;
   logic       acc;
   logic       wr;
   logic [2:0] act;
   logic       any_p;

   assign acc = i_apb.psel && i_apb.penable;
   assign wr  = acc && i_apb.pwrite;
   assign wr_req1 = wr && (i_apb.paddr == `PIR_OFF_REQ1);
   assign wr_req2 = wr && (i_apb.paddr == `PIR_OFF_REQ2);

   // Serial bits exist only with the port
   assign en1_mask   = HAS_SERIAL ? `PIR_MASK_EN1 : `PIR_MASK_EN1_NSER;
   assign req1_wmask = HAS_SERIAL ? `PIR_MASK_REQ1_WR
                                  : `PIR_MASK_REQ1_NSR;
   assign req1_set   = i_src.req1_set & `PIR_MASK_REQ1_WR;

   // Timer, converter and tx flags
   pir_flag_reg u_req1
   (
      .i_clk   (i_clk),
      .i_nrst  (i_nrst),
      .i_we    (wr_req1),
      .i_wdata (i_apb.pwdata[7:0]),
      .i_wmask (req1_wmask),
      .i_set   (req1_set),
      .o_q     (req1_q)
   );

   // Comparator flag
   pir_flag_reg u_req2
   (
      .i_clk   (i_clk),
      .i_nrst  (i_nrst),
      .i_we    (wr_req2),
      .i_wdata (i_apb.pwdata[7:0]),
      .i_wmask (`PIR_MASK_REQ2),
      .i_set   (i_src.req2_set),
      .o_q     (req2_q)
   );

   // Read-only receive flag tracks the serial port
   always_comb
   begin
      req1_rd = req1_q;
      req1_rd[`PIR_BIT_RX] = HAS_SERIAL && i_serial_rx_pending;
   end

   // PWM flags mirror module flags, unwritable here
   assign req3_rd = {1'b0, i_src.pwm_flags, 4'h0};

   // Pending and enabled sources
   assign any_p = |(req1_rd & s_q.en1 & en1_mask)
                | |(req2_q & s_q.en2 & `PIR_MASK_EN2)
                | |(req3_rd & s_q.en3 & `PIR_MASK_EN3);

   assign act[`PIR_ST_REQ1] = |(req1_rd & s_q.en1);
   assign act[`PIR_ST_REQ2] = |(req2_q & s_q.en2);
   assign act[`PIR_ST_REQ3] = |(req3_rd & s_q.en3);

   always_comb
   begin
      s_d = s_q;
      s_d.act_prev = act;
      // Sticky status sets on a new enabled request, set beats clear
      if (wr && (i_apb.paddr == `PIR_OFF_IRQ_STAT))
         s_d.stat = s_q.stat & ~i_apb.pwdata[2:0];
      s_d.stat = s_d.stat | (act & ~s_q.act_prev);
      case (s_q.bus)
         PIR_IDLE:
         begin
            // Read data registered at setup, shown in the access cycle
            if (i_apb.psel && !i_apb.penable)
            begin
               s_d.bus = PIR_ACCESS;
               if (!i_apb.pwrite)
               begin
                  s_d.rdata = 32'h0000_0000;
                  case (i_apb.paddr)
                     `PIR_OFF_CORE:     s_d.rdata[7:0] = s_q.core;
                     `PIR_OFF_OPTION:   s_d.rdata[7:0] = s_q.option;
                     `PIR_OFF_EN1:      s_d.rdata[7:0] = s_q.en1;
                     `PIR_OFF_EN2:      s_d.rdata[7:0] = s_q.en2;
                     `PIR_OFF_EN3:      s_d.rdata[7:0] = s_q.en3;
                     `PIR_OFF_REQ1:     s_d.rdata[7:0] = req1_rd;
                     `PIR_OFF_REQ2:     s_d.rdata[7:0] = req2_q;
                     `PIR_OFF_REQ3:     s_d.rdata[7:0] = req3_rd;
                     `PIR_OFF_IRQ_STAT: s_d.rdata[2:0] = s_q.stat;
                     `PIR_OFF_IRQ_MASK: s_d.rdata[2:0] = s_q.mask;
                     default:           s_d.rdata = 32'h0000_0000;
                  endcase
               end
            end
         end
         PIR_ACCESS:
         begin
            s_d.bus = PIR_IDLE;
            if (i_apb.pwrite)
            begin
               case (i_apb.paddr)
                  `PIR_OFF_CORE:
                     s_d.core = (i_apb.pwdata[7:0] & `PIR_MASK_CORE_WR)
                              | {7'h00, i_core_flags[0]};
                  `PIR_OFF_OPTION:
                     s_d.option = i_apb.pwdata[7:0] & `PIR_MASK_OPTION;
                  `PIR_OFF_EN1:
                     s_d.en1 = i_apb.pwdata[7:0] & en1_mask;
                  `PIR_OFF_EN2:
                     s_d.en2 = i_apb.pwdata[7:0] & `PIR_MASK_EN2;
                  `PIR_OFF_EN3:
                     s_d.en3 = i_apb.pwdata[7:0] & `PIR_MASK_EN3;
                  `PIR_OFF_IRQ_MASK:
                     s_d.mask = i_apb.pwdata[2:0];
                  default:
                     s_d.mask = s_d.mask;
               endcase
            end
         end
         default:
            s_d.bus = PIR_IDLE;
      endcase
      // Read-only core flag follows its source
      s_d.core[0] = i_core_flags[0];
      s_d.periph = any_p && s_q.core[`PIR_BIT_PERIPHERAL_GROUP_ENABLE];
      s_d.cpu = s_q.core[`PIR_BIT_GIE]
             && (s_d.periph || (|i_core_flags[2:1]));
   end

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         s_q        <= '0;
         s_q.bus    <= PIR_IDLE;
      end
      else
         s_q <= s_d;
   end

   always_comb
   begin
      o_apb.pready  = (s_q.bus == PIR_ACCESS);
      o_apb.pslverr = 1'b0;
      o_apb.prdata  = s_q.rdata;
   end

   assign o_periph_irq = s_q.periph;
   assign o_cpu_irq    = s_q.cpu && s_q.core[`PIR_BIT_GIE];
   assign o_irq        = |(s_q.stat & s_q.mask);
endmodule : pir_regs

/* File: tb/pir_periph_model.sv */
// Model of the peripherals that raise interrupt flags.
// Assumes tasks are called just after a rising clock edge.
`timescale 1ns/1ns
module pir_periph_model
(
   // Clock
   input  wire logic         i_clk,
   // Sources
   output pir_pkg::pir_src_t o_src,
   output logic              o_rx
);
   import pir_pkg::*;
   initial
   begin
      o_src = '0;
      o_rx  = 1'b0;
   end
   // One-cycle comparator event
   task cmp_event;
      @(posedge i_clk);
      o_src.req2_set <= 8'h20;
      @(posedge i_clk);
      o_src.req2_set <= 8'h00;
   endtask : cmp_event
   // One-cycle timer, converter and tx events
   task req1_event(input logic [7:0] ev);
      @(posedge i_clk);
      o_src.req1_set <= ev;
      @(posedge i_clk);
      o_src.req1_set <= 8'h00;
   endtask : req1_event
   // Flag levels kept inside the PWM and serial modules
   task levels(input logic [2:0] pwm, input logic rx);
      @(posedge i_clk);
      o_src.pwm_flags <= pwm;
      o_rx            <= rx;
   endtask : levels
endmodule : pir_periph_model

/* File: tb/pir_regs_asserts.sv */
// Port checker for the peripheral interrupt register block.
// Assumes one clock and the asynchronous active low reset.
`timescale 1ns/1ns
module pir_regs_asserts
(
   // Watched ports
   input wire logic                  i_clk,
   input wire logic                  i_nrst,
   input wire pir_pkg::pir_apb_req_t i_apb,
   input wire pir_pkg::pir_apb_rsp_t o_apb,
   input wire logic                  o_periph_irq,
   input wire logic                  o_cpu_irq,
   input wire logic                  o_irq
);
   import pir_pkg::*;
   logic        rd;
   logic [11:0] a;
   logic [7:0]  d;
   assign rd = i_apb.psel && i_apb.penable && !i_apb.pwrite;
   assign a  = i_apb.paddr;
   assign d  = o_apb.prdata[7:0];
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   a_no_slave_err: assert property (!o_apb.pslverr)
      else $error("slave error raised");
   a_setup_ready: assert property
      (i_apb.psel && !i_apb.penable |=> o_apb.pready)
      else $error("no ready after setup");
   a_reset_quiet: assert property
      ($rose(i_nrst) |-> !o_periph_irq && !o_cpu_irq && !o_irq)
      else $error("irq high after reset");
   a_unmapped_zero: assert property
      (rd && a > 12'h024 |-> o_apb.prdata == 32'h0)
      else $error("unmapped read not zero");
   a_upper_zero: assert property (rd |-> o_apb.prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   a_en2_bits: assert property (rd && a == 12'h00C |-> (d & 8'hDF) == 0)
      else $error("enable two spare bit set");
   a_en3_bits: assert property (rd && a == 12'h010 |-> (d & 8'h8F) == 0)
      else $error("enable three spare bit set");
   a_req1_bits: assert property (rd && a == 12'h014 |-> d[3:2] == 2'h0)
      else $error("request one spare bit set");
   a_req2_bits: assert property (rd && a == 12'h018 |-> (d & 8'hDF) == 0)
      else $error("request two spare bit set");
   a_req3_bits: assert property (rd && a == 12'h01C |-> (d & 8'h8F) == 0)
      else $error("request three spare bit set");
endmodule : pir_regs_asserts
bind pir_regs pir_regs_asserts pir_regs_asserts_i (.i_clk(i_clk),
   .i_nrst(i_nrst), .i_apb(i_apb), .o_apb(o_apb),
   .o_periph_irq(o_periph_irq), .o_cpu_irq(o_cpu_irq), .o_irq(o_irq));

/* File: tb/tb_pir_regs.sv */
// Self-checking bench of the peripheral interrupt register block.
// Assumes the checker is bound and the peripheral model is present.
`timescale 1ns/1ns
module tb_pir_regs;
   import pir_pkg::*;
   logic         i_clk;
   logic         i_nrst;
   pir_apb_req_t i_apb;
   pir_apb_rsp_t o_apb;
   pir_src_t     src;
   logic         rx;
   logic         p_irq;
   logic         c_irq;
   logic         irq;
   logic [2:0]   cflags;
   int           bad_count;
   int           checks_done;
   pir_regs pir_regs_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_apb(i_apb),
      .o_apb(o_apb), .i_src(src), .i_serial_rx_pending(rx),
      .i_core_flags(cflags), .o_periph_irq(p_irq), .o_cpu_irq(c_irq),
      .o_irq(irq));
   pir_periph_model pir_periph_model_i (.i_clk(i_clk), .o_src(src),
      .o_rx(rx));
   initial
   begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   task chk(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e)
      begin
         bad_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task test_done;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : test_done
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] r);
      int n;
      n = 0;
      r = 32'h0;
      i_apb <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:d};
      @(posedge i_clk);
      i_apb.penable <= 1'b1;
      @(posedge i_clk);
      while (o_apb.pready !== 1'b1 && n < 20)
      begin
         @(posedge i_clk);
         n++;
      end
      if (n >= 20)
      begin
         bad_count++;
         test_done();
      end
      r = o_apb.prdata;
      i_apb.psel    <= 1'b0;
      i_apb.penable <= 1'b0;
      @(posedge i_clk);
   endtask : apb
   task wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
   endtask : wr
   task rd(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] r;
      apb(1'b0, a, 32'h0, r);
      chk(r, e);
   endtask : rd
   task wirq(input logic [2:0] e);
      int n;
      n = 0;
      @(negedge i_clk);
      while ({p_irq, c_irq, irq} !== e && n < 10)
      begin
         @(negedge i_clk);
         n++;
      end
      repeat (3) @(negedge i_clk);
      chk({29'h0, p_irq, c_irq, irq}, {29'h0, e});
      @(posedge i_clk);
   endtask : wirq
   task t_access;
      logic [11:0] a [9] = '{12'h000, 12'h008, 12'h00C, 12'h010,
                             12'h014, 12'h018, 12'h01C, 12'h004,
                             12'h024};
      logic [7:0]  e [9] = '{8'hFE, 8'hF3, 8'h20, 8'h70,
                             8'hD3, 8'h20, 8'h00, 8'hFF, 8'h07};
      for (int k = 0; k < 11; k++)
         rd(12'(4 * k), 32'h0);
      for (int k = 0; k < 9; k++)
      begin
         wr(a[k], 32'hFFFFFFFF);
         rd(a[k], {24'h0, e[k]});
         wr(a[k], 32'h0);
      end
      wr(12'h028, 32'hFFFFFFFF);
      rd(12'h028, 32'h0);
      $display("access test done");
   endtask : t_access
   task t_flow;
      pir_periph_model_i.cmp_event();
      rd(12'h018, 32'h20);
      wirq(3'b000);
      wr(12'h018, 32'h0);
      wr(12'h00C, 32'h20);
      wr(12'h000, 32'h80);
      wr(12'h024, 32'h7);
      pir_periph_model_i.cmp_event();
      rd(12'h018, 32'h20);
      wirq(3'b001);
      wr(12'h018, 32'h0);
      wr(12'h000, 32'hC0);
      pir_periph_model_i.cmp_event();
      wirq(3'b111);
      wr(12'h000, 32'h40);
      wirq(3'b101);
      wr(12'h018, 32'h0);
      wr(12'h020, 32'h7);
      wirq(3'b000);
      $display("flow test done");
   endtask : t_flow
   task t_ro;
      wr(12'h024, 32'h0);
      pir_periph_model_i.levels(3'b100, 1'b1);
      wr(12'h01C, 32'h0);
      wr(12'h014, 32'h0);
      rd(12'h01C, 32'h40);
      rd(12'h014, 32'h20);
      wr(12'h010, 32'h40);
      wr(12'h000, 32'hC0);
      wirq(3'b110);
      pir_periph_model_i.levels(3'b000, 1'b0);
      rd(12'h01C, 32'h0);
      wirq(3'b000);
      i_nrst <= 1'b0;
      @(posedge i_clk);
      i_nrst <= 1'b1;
      @(posedge i_clk);
      rd(12'h010, 32'h0);
      rd(12'h000, 32'h0);
      rd(12'h020, 32'h0);
      $display("read-only test done");
   endtask : t_ro
   task t_req1;
      pir_periph_model_i.req1_event(8'hFF);
      rd(12'h014, 32'hD3);
      fork
         wr(12'h014, 32'h0);
         pir_periph_model_i.req1_event(8'h01);
      join
      rd(12'h014, 32'h01);
      wr(12'h008, 32'h01);
      wr(12'h000, 32'h80);
      wirq(3'b000);
      wr(12'h000, 32'hC0);
      wirq(3'b110);
      cflags <= 3'b011;
      wr(12'h000, 32'h80);
      rd(12'h000, 32'h81);
      wirq(3'b010);
      cflags <= 3'b000;
      wr(12'h000, 32'h00);
      wirq(3'b000);
      $display("source test done");
   endtask : t_req1
   initial
   begin
      bad_count   = 0;
      checks_done = 0;
      i_apb       = '0;
      cflags      = 3'h0;
      i_nrst      = 1'b0;
      repeat (2) @(posedge i_clk);
      i_nrst <= 1'b1;
      @(posedge i_clk);
      t_access();
      t_flow();
      t_ro();
      t_req1();
      test_done();
   end
endmodule : tb_pir_regs
